// ===== rtl/swseq_defs.vh
`ifndef SWSEQ_DEFS_VH
`define SWSEQ_DEFS_VH
// APB register byte offsets
`define SWSEQ_CTRL_OFF      12'h000
`define SWSEQ_CNT_OFF       12'h004
`define SWSEQ_STAT_OFF      12'h008
// Control register fields
`define SWSEQ_CTRL_EN       0
`define SWSEQ_CTRL_FILT     1
`define SWSEQ_CTRL_HS       2
`define SWSEQ_CTRL_GSR      3
`define SWSEQ_CTRL_DRIVE    4
`define SWSEQ_CTRL_SCP      5
`define SWSEQ_CTRL_CLKSEL   6
`define SWSEQ_CTRL_RST      32'h00000000
// Count register fields: minus-one encoded, 10 bits each
`define SWSEQ_IOREL_LSB     0
`define SWSEQ_WUNL_LSB      16
`define SWSEQ_IOREL_RST     10'h003
`define SWSEQ_WUNL_RST      10'h004
// Timing
`define SWSEQ_FILT_NS       100
`define SWSEQ_CLK_NS        5
`define SWSEQ_FILT_CYC      ((`SWSEQ_FILT_NS + `SWSEQ_CLK_NS - 1) / `SWSEQ_CLK_NS)
`define SWSEQ_GWE_DLY_CYC   8
`endif

// ===== rtl/swseq_top.v
`timescale 1ns/1ps
`default_nettype none
`include "swseq_defs.vh"
module swseq_top #(
   parameter CW       = 10,
   parameter FILT_CYC = `SWSEQ_FILT_CYC,
   parameter GWE_DLY  = `SWSEQ_GWE_DLY_CYC
) (
   // System
   input  wire        CLK_SYS,
   input  wire        RESETN,

   // APB slave
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output wire        PREADY,
   output reg  [31:0] PRDATA,
   output wire        PSLVERR,

   // Suspend request and sleep control pins
   input  wire        SUSP_REQ_IN,
   input  wire        SLEEP_CONTROL_PINS,

   // Wake timer clock enables (two sources)
   input  wire        WAKE_TICK_INT,
   input  wire        WAKE_TICK_ALT,

   // Application handshake, sampled on application clock edge strobe
   input  wire        APP_CLK_RISE,
   input  wire        SLEEP_ACK_IN,
   output reg         SLEEP_REQUEST_OUT,

   // Wake status pin (three signals) and user I/O path
   input  wire        AWAKE_STAT_I,
   output reg         AWAKE_STAT_O,
   output reg         AWAKE_STAT_OE,
   input  wire        USER_STAT_O,
   input  wire        USER_STAT_OE,

   // Global controls to fabric
   output reg         IO_SUSPENDED,
   output reg         WRITE_PROTECT,
   output reg         GLOBAL_RESET,
   output wire        CFG_PINS_ACTIVE
);
   localparam ST_ACTIVE = 3'h0;
   localparam ST_REQ    = 3'h1;
   localparam ST_FREEZE = 3'h2;
   localparam ST_SUSP   = 3'h3;
   localparam ST_GSR    = 3'h4;
   localparam ST_WAIT   = 3'h5;
   localparam ST_WAKE   = 3'h6;

   reg  [31:0]   ctrl_reg;
   reg  [CW-1:0] io_release_count_reg;
   reg  [CW-1:0] write_unlock_count_reg;
   reg  [2:0]    state_reg;
   reg  [2:0]    state_next;
   reg  [CW:0]   wake_cnt_reg;
   reg  [7:0]    dly_reg;
   reg  [7:0]    filt_cnt_reg;
   reg           req_filt_reg;
   reg  [31:0]   rd_mux;
   wire          feat_en    = ctrl_reg[`SWSEQ_CTRL_EN];
   wire          hs_en      = ctrl_reg[`SWSEQ_CTRL_HS];
   wire          wake_timer_clock_sel = ctrl_reg[`SWSEQ_CTRL_CLKSEL];
   wire          wake_tick;
   wire          req_eff;
   wire          wr_en;
   wire          io_done;
   wire          wr_done;
   wire          count_tick;

   // Register address match
   function reg_hit;
      input [11:0] addr;
      input [11:0] off;
      begin
         reg_hit = (addr == off);
      end
   endfunction

   // Counter has passed the programmed minus-one count
   function count_done;
      input [CW:0]   cnt;
      input [CW-1:0] prog;
      begin
         count_done = (cnt > {1'b0, prog});
      end
   endfunction

   // This tick is the last one of the programmed count
   function count_last;
      input [CW:0]   cnt;
      input [CW-1:0] prog;
      begin
         count_last = (cnt >= {1'b0, prog});
      end
   endfunction

   // Status level per state; stays high through the freeze delay
   function awake_level;
      input [2:0] st;
      begin
         case (st)
            ST_SUSP: awake_level = 1'b0;
            ST_GSR:  awake_level = 1'b0;
            default: awake_level = 1'b1;
         endcase
      end
   endfunction

   // APB: zero wait, no errors
   assign PREADY  = 1'b1;
   assign PSLVERR = 1'b0;
   assign wr_en   = PSEL & PENABLE & PWRITE;
   assign CFG_PINS_ACTIVE = 1'b1;

   // Register writes
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_reg               <= `SWSEQ_CTRL_RST;
         io_release_count_reg   <= `SWSEQ_IOREL_RST;
         write_unlock_count_reg <= `SWSEQ_WUNL_RST;
      end else if (wr_en) begin
         if (reg_hit(PADDR, `SWSEQ_CTRL_OFF))
            ctrl_reg <= {25'h0000000, PWDATA[6:0]};
         if (reg_hit(PADDR, `SWSEQ_CNT_OFF)) begin
            io_release_count_reg   <= PWDATA[`SWSEQ_IOREL_LSB +: CW];
            write_unlock_count_reg <= PWDATA[`SWSEQ_WUNL_LSB +: CW];
         end
      end
   end

   // Read mux for the addressed register
   always @* begin
      rd_mux = 32'h00000000;
      if (reg_hit(PADDR, `SWSEQ_CTRL_OFF))
         rd_mux = ctrl_reg;
      else if (reg_hit(PADDR, `SWSEQ_CNT_OFF)) begin
         rd_mux[`SWSEQ_IOREL_LSB +: CW] = io_release_count_reg;
         rd_mux[`SWSEQ_WUNL_LSB +: CW]  = write_unlock_count_reg;
      end else if (reg_hit(PADDR, `SWSEQ_STAT_OFF))
         rd_mux = {14'h0000, wake_cnt_reg, state_reg, req_filt_reg,
                   IO_SUSPENDED, WRITE_PROTECT, SLEEP_REQUEST_OUT};
   end

   // Read data captured in the setup cycle, stands through the access cycle
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN)
         PRDATA <= 32'h00000000;
      else if (PSEL && !PENABLE && !PWRITE)
         PRDATA <= rd_mux;
   end

   // Single selected wake clock enable
   assign wake_tick = wake_timer_clock_sel ? WAKE_TICK_ALT : WAKE_TICK_INT;

   // Glitch filter: input must hold FILT_CYC cycles to change
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         req_filt_reg <= 1'b0;
         filt_cnt_reg <= 8'h00;
      end else if (!ctrl_reg[`SWSEQ_CTRL_FILT]) begin
         req_filt_reg <= SUSP_REQ_IN;
         filt_cnt_reg <= 8'h00;
      end else if (SUSP_REQ_IN == req_filt_reg) begin
         filt_cnt_reg <= 8'h00;
      end else if (filt_cnt_reg >= FILT_CYC[7:0] - 8'h01) begin
         req_filt_reg <= SUSP_REQ_IN;
         filt_cnt_reg <= 8'h00;
      end else begin
         filt_cnt_reg <= filt_cnt_reg + 8'h01;
      end
   end

   // Request ignored when feature off
   assign req_eff = feat_en & req_filt_reg;
   assign io_done = count_done(wake_cnt_reg, io_release_count_reg);
   assign wr_done = count_done(wake_cnt_reg, write_unlock_count_reg);
   assign count_tick = (state_reg == ST_WAKE) && AWAKE_STAT_I && wake_tick;

   // Sequencer next state
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_ACTIVE: if (req_eff)
                       state_next = hs_en ? ST_REQ : ST_FREEZE;
         ST_REQ:    if (!req_eff)
                       state_next = ST_ACTIVE;
                    else if (APP_CLK_RISE && SLEEP_ACK_IN && SLEEP_REQUEST_OUT)
                       state_next = ST_FREEZE;
         ST_FREEZE: if (dly_reg >= GWE_DLY[7:0])
                       state_next = ST_SUSP;
         ST_SUSP:   if (!req_eff && (!ctrl_reg[`SWSEQ_CTRL_SCP] || SLEEP_CONTROL_PINS))
                       state_next = ctrl_reg[`SWSEQ_CTRL_GSR] ? ST_GSR : ST_WAIT;
         ST_GSR:    state_next = ST_WAIT;
         ST_WAIT:   if (AWAKE_STAT_I)
                       state_next = ST_WAKE;
         ST_WAKE:   if (io_done && wr_done)
                       state_next = ST_ACTIVE;
         default:   state_next = ST_ACTIVE;
      endcase
   end

   // Sequencer state and freeze delay counter
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= ST_ACTIVE;
         dly_reg   <= 8'h00;
      end else begin
         state_reg <= state_next;
         dly_reg   <= (state_reg == ST_FREEZE) ? dly_reg + 8'h01 : 8'h00;
      end
   end

   // Request output follows application clock edge, drops on abort
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN)
         SLEEP_REQUEST_OUT <= 1'b0;
      else if (state_reg != ST_REQ || !req_eff)
         SLEEP_REQUEST_OUT <= 1'b0;
      else if (APP_CLK_RISE)
         SLEEP_REQUEST_OUT <= 1'b1;
   end

   // One-cycle global reset pulse before the status pin rises
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN)
         GLOBAL_RESET <= 1'b0;
      else
         GLOBAL_RESET <= (state_next == ST_GSR);
   end

   // Wake counter cleared on entry, counts only while status high
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN)
         wake_cnt_reg <= {(CW+1){1'b0}};
      else if (state_reg == ST_SUSP)
         wake_cnt_reg <= {(CW+1){1'b0}};
      else if (count_tick)
         wake_cnt_reg <= wake_cnt_reg + {{CW{1'b0}}, 1'b1};
   end

   // Pin suspend flag: set on entry, cleared on the last release tick
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN)
         IO_SUSPENDED <= 1'b0;
      else if (state_next == ST_FREEZE)
         IO_SUSPENDED <= 1'b1;
      else if (count_tick && count_last(wake_cnt_reg, io_release_count_reg))
         IO_SUSPENDED <= 1'b0;
   end

   // Write protect: set after the freeze delay, cleared on the last unlock tick
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN)
         WRITE_PROTECT <= 1'b0;
      else if (state_reg == ST_FREEZE && state_next == ST_SUSP)
         WRITE_PROTECT <= 1'b1;
      else if (count_tick && count_last(wake_cnt_reg, write_unlock_count_reg))
         WRITE_PROTECT <= 1'b0;
   end

   // Wake status pin drive
   always @* begin
      if (!feat_en) begin
         AWAKE_STAT_O  = USER_STAT_O;
         AWAKE_STAT_OE = USER_STAT_OE;
      end else begin
         AWAKE_STAT_O  = awake_level(state_reg);
         AWAKE_STAT_OE = ctrl_reg[`SWSEQ_CTRL_DRIVE] | ~AWAKE_STAT_O;
      end
   end
endmodule
`default_nettype wire

// ===== verification/swseq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module swseq_chk #(
   parameter GWE_DLY = 8
) (
   // Clock, reset and register bus
   input wire logic        CLK_SYS,
   input wire logic        RESETN,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   // Pins and global controls
   input wire logic        APP_CLK_RISE,
   input wire logic        AWAKE_STAT_I,
   input wire logic        AWAKE_STAT_O,
   input wire logic        AWAKE_STAT_OE,
   input wire logic        USER_STAT_OE,
   input wire logic        SLEEP_REQUEST_OUT,
   input wire logic        IO_SUSPENDED,
   input wire logic        WRITE_PROTECT,
   input wire logic        GLOBAL_RESET
);
   localparam int DLY_MAX = GWE_DLY + 8;
   logic [6:0] ctrl_reg;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   // Shadow of the control word
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN)
         ctrl_reg <= 7'h00;
      else if (PSEL && PENABLE && PWRITE && PADDR == 12'h000)
         ctrl_reg <= PWDATA[6:0];
   end
   chk_off_ignores_req: assert property (!ctrl_reg[0] && !IO_SUSPENDED |=> !IO_SUSPENDED)
      else $error("suspend entered while feature off");
   chk_user_owns_pin: assert property (!ctrl_reg[0] |-> AWAKE_STAT_OE == USER_STAT_OE)
      else $error("status pin not user owned");
   chk_open_drain: assert property (ctrl_reg[0] && !ctrl_reg[4] && AWAKE_STAT_OE |-> !AWAKE_STAT_O)
      else $error("open drain status driven high");
   chk_io_first: assert property ($fell(WRITE_PROTECT) |-> !IO_SUSPENDED)
      else $error("write unlock before pin release");
   chk_stall_low: assert property (IO_SUSPENDED && !AWAKE_STAT_I |=> IO_SUSPENDED)
      else $error("pins released while status held low");
   chk_freeze_delay: assert property ($rose(IO_SUSPENDED) |-> !WRITE_PROTECT ##[1:DLY_MAX] WRITE_PROTECT)
      else $error("write protect late or missing");
   chk_gsr_pulse: assert property (GLOBAL_RESET |-> ctrl_reg[3] && WRITE_PROTECT ##1 !GLOBAL_RESET)
      else $error("global reset pulse misplaced");
   chk_req_on_app_edge: assert property ($rose(SLEEP_REQUEST_OUT) |-> $past(APP_CLK_RISE) && ctrl_reg[2])
      else $error("request out off application edge");
   cover property ($rose(WRITE_PROTECT));
   cover property ($fell(IO_SUSPENDED));
   cover property (GLOBAL_RESET);
endmodule
`default_nettype wire

// ===== verification/swseq_far.sv
`timescale 1ns/1ps
`default_nettype none
module swseq_far (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Application handshake and wake clocks
   input  wire logic req_out,
   output var  logic app_rise,
   output var  logic ack,
   output var  logic tick_int,
   output var  logic tick_alt,
   // Status wire
   input  wire logic stat_o,
   input  wire logic stat_oe,
   input  wire logic hold_low,
   output wire logic stat_wire
);
   logic [3:0] div_reg;
   logic [1:0] wait_reg;
   // Pull-up wire, low if anyone sinks it; no test-port or readback traffic
   assign stat_wire = !(hold_low || (stat_oe && !stat_o));
   // Application edges, wake ticks and a slow acknowledge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {div_reg, wait_reg, app_rise, ack, tick_int, tick_alt} <= '0;
      end else begin
         div_reg  <= (div_reg == 4'hE) ? 4'h0 : div_reg + 4'h1;
         app_rise <= div_reg[1:0] == 2'h3;
         tick_int <= div_reg % 3 == 0;
         tick_alt <= div_reg % 5 == 0;
         if (app_rise) begin // Ack after quiescing, held until request drops
            wait_reg <= req_out ? wait_reg + 2'h1 : 2'h0;
            ack      <= req_out && (ack || wait_reg == 2'h2);
         end
      end
   end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        CLK_SYS, RESETN, PSEL, PENABLE, PWRITE, SUSP_REQ_IN;
   int          gsr_cnt = 0;
   logic        SLEEP_CONTROL_PINS, USER_STAT_O, USER_STAT_OE, hold_low;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, rdata;
   wire  [31:0] PRDATA;
   wire         PREADY, PSLVERR, WAKE_TICK_INT, WAKE_TICK_ALT, APP_CLK_RISE, SLEEP_ACK_IN;
   wire         SLEEP_REQUEST_OUT, AWAKE_STAT_I, AWAKE_STAT_O, AWAKE_STAT_OE;
   wire         IO_SUSPENDED, WRITE_PROTECT, GLOBAL_RESET, CFG_PINS_ACTIVE;
   int          num_errors, checks;
   swseq_top #(.GWE_DLY(2)) u_swseq_top (.*);
   swseq_far u_swseq_far (.clk(CLK_SYS), .rst_n(RESETN), .req_out(SLEEP_REQUEST_OUT),
      .app_rise(APP_CLK_RISE), .ack(SLEEP_ACK_IN), .tick_int(WAKE_TICK_INT),
      .tick_alt(WAKE_TICK_ALT), .stat_o(AWAKE_STAT_O), .stat_oe(AWAKE_STAT_OE),
      .hold_low(hold_low), .stat_wire(AWAKE_STAT_I));
   // Clock and reset pulse catcher
   always #2.5 CLK_SYS = !CLK_SYS;
   always @(posedge CLK_SYS) if (GLOBAL_RESET === 1'b1) gsr_cnt <= gsr_cnt + 1;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until PREADY is sampled
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK_SYS);
         n++;
      end while (PREADY !== 1'b1 && n < 16);
      rdata = PRDATA;
      chk({PREADY, PSLVERR}, 2'b10);
      {PSEL, PENABLE} <= 2'b00;
      @(posedge CLK_SYS);
   endtask
   // Suspend, stall, then wake and count wake ticks
   task automatic cycle(input logic [6:0] c, input logic [31:0] cnt, input int eio, ewu);
      int n, t, nio, g0;
      logic up;
      apb(12'h000, 1'b1, {25'h0, c});
      apb(12'h004, 1'b1, cnt);
      {t, nio} = '0;
      g0 = gsr_cnt;
      up = 1'b0;
      SUSP_REQ_IN <= 1'b1;
      if (c[1]) begin
         repeat (10) @(posedge CLK_SYS);
         SUSP_REQ_IN <= 1'b0;
         repeat (30) @(posedge CLK_SYS);
         chk(IO_SUSPENDED, 0);
         SUSP_REQ_IN <= 1'b1;
      end
      for (n = 0; n < 99 && c[2] && SLEEP_REQUEST_OUT !== 1'b1; n++) @(posedge CLK_SYS);
      chk({SLEEP_REQUEST_OUT, IO_SUSPENDED}, {c[2], 1'b0});
      for (n = 0; n < 400 && AWAKE_STAT_I !== 1'b0; n++) @(posedge CLK_SYS);
      chk({IO_SUSPENDED, WRITE_PROTECT, AWAKE_STAT_I}, 3'b110);
      chk(CFG_PINS_ACTIVE, 1);
      {hold_low, SLEEP_CONTROL_PINS, SUSP_REQ_IN} <= {!c[5], 2'b00};
      repeat (60) @(posedge CLK_SYS);
      chk({IO_SUSPENDED, WRITE_PROTECT}, 2'b11);
      {hold_low, SLEEP_CONTROL_PINS} <= 2'b01;
      for (n = 0; n < 8000 && WRITE_PROTECT !== 1'b0; n++) begin
         @(posedge CLK_SYS);
         if (IO_SUSPENDED === 1'b0 && nio == 0) nio = t;
         if (up && AWAKE_STAT_I && (c[6] ? WAKE_TICK_ALT : WAKE_TICK_INT)) t++;
         up = up || AWAKE_STAT_I;
      end
      chk(nio, eio);
      chk(t, ewu);
      chk(gsr_cnt - g0, c[3]);
      chk({AWAKE_STAT_I, AWAKE_STAT_OE}, {1'b1, c[4]});
      $display("test ctrl %h done", c);
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog
   initial begin
      #400000;
      num_errors++;
      stop_test;
   end
   // Main sequence
   initial begin
      {CLK_SYS, RESETN, PSEL, PENABLE, PWRITE, PADDR, PWDATA, SUSP_REQ_IN} = '0;
      {SLEEP_CONTROL_PINS, USER_STAT_O, hold_low, num_errors, checks} = '0;
      USER_STAT_OE = 1'b1;
      repeat (4) @(posedge CLK_SYS);
      RESETN <= 1'b1;
      apb(12'h004, 1'b0, 32'h0);
      chk(rdata, 32'h00040003);
      apb(12'h00C, 1'b0, 32'h0);
      chk(rdata, 32'h0);
      SUSP_REQ_IN <= 1'b1;
      repeat (60) @(posedge CLK_SYS);
      chk({IO_SUSPENDED, WRITE_PROTECT, AWAKE_STAT_OE}, 3'b001);
      SUSP_REQ_IN <= 1'b0;
      $display("test disabled done");
      cycle(7'h01, 32'h00040003, 4, 5);
      cycle(7'h5B, 32'h03FF0000, 1, 1024);
      cycle(7'h25, 32'h00020001, 2, 3);
      stop_test;
   end
endmodule
bind swseq_top swseq_chk #(.GWE_DLY(GWE_DLY)) u_swseq_chk (.*);
`default_nettype wire
